// ---- chgpins.sv ----
// Purpose: Status/alert pins, enable gating, data-line drive, detection, current limit
// Assumes: Pins arrive asynchronously; register bus is on SYS_CLK
// Notes:   Open-drain pins have output enables only; the wire is resolved outside
`timescale 1ns/100ps

// Operation
// - Status low while charging with charge on, else released
// - Any fault blinks status at 1 Hz
// - Disable bit stops status output entirely
// - Alert is one low 256 us pulse
// - Boost needs config bit and pin high
// - Charge needs config bit and pin low
// - D+ drives level when source or boost
// - D- drives level when source or boost
// - Run contact, primary, secondary, high-voltage detection
// - Limit is smaller of pin and register
// - Pin limit ignored when enable bit clear
module chgpins (
  // Clock, reset, enable
  input  wire  logic       SYS_CLK,
  input  wire  logic       RST,
  input  wire  logic       CE,
  // Register bus
  input  wire  logic [7:0] ADDR,
  input  wire  logic [7:0] WDATA,
  input  wire  logic       WR,
  input  wire  logic       RD,
  output logic       [7:0] RDATA,
  // Charger core status
  input  wire  logic       CHARGING,
  input  wire  logic       FAULT,
  input  wire  logic       SRC_PRESENT,
  input  wire  logic [5:0] PIN_LIMIT,
  // Host pins
  input  wire  logic       BOOST_PIN,
  input  wire  logic       CHARGE_EN_N,
  input  wire  logic       DPLUS_IN,
  input  wire  logic       DMINUS_IN,
  // Status and alert open-drain enables
  output logic             STAT_OE,
  output logic             ALERT_OE,
  // Data-line drivers
  output logic             DPLUS_OE,
  output logic       [2:0] DPLUS_LEVEL,
  output logic             DMINUS_OE,
  output logic       [2:0] DMINUS_LEVEL,
  // Core controls
  output logic             BOOST_ON,
  output logic             CHARGE_ON,
  output logic       [5:0] EFF_LIMIT,
  output logic       [2:0] PORT_TYPE,
  output logic             IRQ
);

  // Register state
  logic [7:0]  ctrl_q;                     // Control bits
  logic [5:0]  drive_q;                    // D- level [5:3], D+ level [2:0]
  logic [5:0]  lim_q;                      // Register input limit
  logic [7:0]  mask_q;                     // Interrupt mask
  logic [2:0]  event_q;                    // Sticky events
  // Pin synchronisers, three stages each
  logic [2:0]  sy_boost_q, sy_ce_q, sy_dp_q, sy_dm_q;
  logic        boost_pin_q, ce_pin_q, dp_q, dm_q;
  // Status and alert timing
  logic [25:0] blink_cnt_q;
  logic        blink_q;
  logic [15:0] alert_cnt_q, alert_hi_q;    // Alert countdown, alert width so far
  logic        chg_prev_q, fault_prev_q;
  // Detection
  chgpins_pkg::det_state_t  ds_q;
  chgpins_pkg::det_result_t res_q;
  logic        src_prev_q;
  logic        det_done_ev;
  logic        new_event;
  logic        rd_event;

  // Register bus decode of a read of the event register
  assign rd_event = RD && (ADDR == chgpins_pkg::OFS_EVENT);

  // Smaller of two limits
  function automatic logic [5:0] min6(input logic [5:0] a, input logic [5:0] b);
    min6 = (a < b) ? a : b;
  endfunction

  // Register writes
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_q  <= chgpins_pkg::CTRL_RESET;
      drive_q <= 6'h00;
      lim_q   <= chgpins_pkg::LIM_RESET;
      mask_q  <= chgpins_pkg::MASK_RESET;
    end else if (CE && WR) begin
      case (ADDR)
        chgpins_pkg::OFS_CTRL:  ctrl_q  <= WDATA;
        chgpins_pkg::OFS_DRIVE: drive_q <= WDATA[5:0];
        chgpins_pkg::OFS_CURRENT_LIMIT_RESISTOR_PIN:  lim_q   <= WDATA[5:0];
        chgpins_pkg::OFS_MASK:  mask_q  <= WDATA;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (CE) begin
      RDATA <= 8'h00;
      if (RD) begin
        case (ADDR)
          chgpins_pkg::OFS_CTRL:  RDATA <= ctrl_q;
          chgpins_pkg::OFS_DRIVE: RDATA <= {2'h0, drive_q};
          chgpins_pkg::OFS_CURRENT_LIMIT_RESISTOR_PIN:  RDATA <= {2'h0, lim_q};
          chgpins_pkg::OFS_STATE: RDATA <= {res_q, ce_pin_q, boost_pin_q, FAULT, CHARGING,
                                            SRC_PRESENT};
          chgpins_pkg::OFS_EVENT: RDATA <= {5'h00, event_q};
          chgpins_pkg::OFS_MASK:  RDATA <= mask_q;
          default:                RDATA <= 8'h00;
        endcase
      end
    end
  end

  // Pin synchronisers; only the second and third stages are read
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sy_boost_q <= 3'h0;
      sy_ce_q    <= 3'h7;
      sy_dp_q    <= 3'h0;
      sy_dm_q    <= 3'h0;
    end else if (CE) begin
      sy_boost_q <= {sy_boost_q[1:0], BOOST_PIN};
      sy_ce_q    <= {sy_ce_q[1:0], CHARGE_EN_N};
      sy_dp_q    <= {sy_dp_q[1:0], DPLUS_IN};
      sy_dm_q    <= {sy_dm_q[1:0], DMINUS_IN};
    end
  end

  // Accept a pin change once stages two and three agree
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      boost_pin_q <= 1'b0;
      ce_pin_q    <= 1'b1;
      dp_q        <= 1'b0;
      dm_q        <= 1'b0;
    end else if (CE) begin
      if (sy_boost_q[1] == sy_boost_q[2]) boost_pin_q <= sy_boost_q[2];
      if (sy_ce_q[1] == sy_ce_q[2])       ce_pin_q    <= sy_ce_q[2];
      if (sy_dp_q[1] == sy_dp_q[2])       dp_q        <= sy_dp_q[2];
      if (sy_dm_q[1] == sy_dm_q[2])       dm_q        <= sy_dm_q[2];
    end
  end

  // Boost and charge gating
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      BOOST_ON  <= 1'b0;
      CHARGE_ON <= 1'b0;
    end else if (CE) begin
      BOOST_ON  <= ctrl_q[chgpins_pkg::CTRL_BOOST] && boost_pin_q;
      CHARGE_ON <= ctrl_q[chgpins_pkg::CTRL_CHARGE] && !ce_pin_q;
    end
  end

  // Effective input current limit
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      EFF_LIMIT <= chgpins_pkg::LIM_RESET;
    end else if (CE) begin
      if (ctrl_q[chgpins_pkg::CTRL_PINLIM])
        EFF_LIMIT <= min6(PIN_LIMIT, lim_q);
      else
        EFF_LIMIT <= lim_q;
    end
  end

  // Data-line drivers, only with a source attached or boost active
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      DPLUS_OE     <= 1'b0;
      DPLUS_LEVEL  <= 3'h0;
      DMINUS_OE    <= 1'b0;
      DMINUS_LEVEL <= 3'h0;
    end else if (CE) begin
      DPLUS_OE     <= (SRC_PRESENT || BOOST_ON) && (drive_q[2:0] != 3'h0);
      DPLUS_LEVEL  <= drive_q[2:0];
      DMINUS_OE    <= (SRC_PRESENT || BOOST_ON) && (drive_q[5:3] != 3'h0);
      DMINUS_LEVEL <= drive_q[5:3];
    end
  end

  // Port detection: contact, primary, secondary, high-voltage, one step a cycle
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ds_q       <= chgpins_pkg::DS_IDLE;
      res_q      <= chgpins_pkg::DET_NONE;
      src_prev_q <= 1'b0;
    end else if (CE) begin
      src_prev_q <= SRC_PRESENT;
      case (ds_q)
        chgpins_pkg::DS_IDLE: begin
          if (SRC_PRESENT && !src_prev_q && ctrl_q[chgpins_pkg::CTRL_DET]) begin
            ds_q  <= chgpins_pkg::DS_DCD;
            res_q <= chgpins_pkg::DET_NONE;
          end
        end
        // Data contact: wait for D+ to read low
        chgpins_pkg::DS_DCD: if (!dp_q) ds_q <= chgpins_pkg::DS_PRIM;
        // Primary: D- follows D+ means a charging port
        chgpins_pkg::DS_PRIM: begin
          if (dm_q) begin
            ds_q <= chgpins_pkg::DS_SEC;
          end else begin
            res_q <= chgpins_pkg::DET_SDP;
            ds_q  <= chgpins_pkg::DS_DONE;
          end
        end
        // Secondary: D+ high marks dedicated port
        chgpins_pkg::DS_SEC: begin
          if (dp_q) begin
            ds_q <= chgpins_pkg::DS_HV;
          end else begin
            res_q <= chgpins_pkg::DET_CDP;
            ds_q  <= chgpins_pkg::DS_DONE;
          end
        end
        // High-voltage adapter check
        chgpins_pkg::DS_HV: begin
          res_q <= (dp_q && dm_q) ? chgpins_pkg::DET_HV : chgpins_pkg::DET_DCP;
          ds_q  <= chgpins_pkg::DS_DONE;
        end
        chgpins_pkg::DS_DONE: if (!SRC_PRESENT) ds_q <= chgpins_pkg::DS_IDLE;
        default: ds_q <= chgpins_pkg::DS_IDLE;
      endcase
    end
  end

  assign det_done_ev = (ds_q == chgpins_pkg::DS_HV) || (ds_q == chgpins_pkg::DS_PRIM && !dm_q)
                     || (ds_q == chgpins_pkg::DS_SEC && !dp_q);

  // Result port
  always_ff @(posedge SYS_CLK) begin
    if (RST) PORT_TYPE <= 3'h0;
    else if (CE) PORT_TYPE <= res_q;
  end

  // Edge memory for event detection
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      chg_prev_q   <= 1'b0;
      fault_prev_q <= 1'b0;
    end else if (CE) begin
      chg_prev_q   <= CHARGING;
      fault_prev_q <= FAULT;
    end
  end

  // Fresh edges only, so a held condition does not retrigger
  assign new_event = (CHARGING != chg_prev_q) || (FAULT && !fault_prev_q) || det_done_ev;

  // Sticky events; a set in the clearing cycle wins
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      event_q <= 3'h0;
    end else if (CE) begin
      event_q <= (rd_event ? 3'h0 : event_q)
               | {det_done_ev, FAULT && !fault_prev_q, CHARGING != chg_prev_q};
    end
  end

  // Interrupt level
  always_ff @(posedge SYS_CLK) begin
    if (RST) IRQ <= 1'b0;
    else if (CE) IRQ <= |(event_q & mask_q[2:0]);
  end

  // Alert pulse timer, fixed length, started by a new event when idle
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      alert_cnt_q <= 16'h0000;
      ALERT_OE    <= 1'b0;
    end else if (CE) begin
      if (alert_cnt_q != 16'h0000) begin
        alert_cnt_q <= alert_cnt_q - 16'h0001;
        ALERT_OE    <= (alert_cnt_q != 16'h0001);
      end else if (new_event) begin
        alert_cnt_q <= 16'(chgpins_pkg::ALERT_CYC);
        ALERT_OE    <= 1'b1;
      end
    end
  end

  // Alert width so far, read only by the width check
  always_ff @(posedge SYS_CLK) begin
    if (RST) alert_hi_q <= 16'h0000;
    else if (CE) alert_hi_q <= ALERT_OE ? alert_hi_q + 16'h0001 : 16'h0000;
  end

  // Blink timer, toggles each half second while a fault stands
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      blink_cnt_q <= 26'h0000000;
      blink_q     <= 1'b0;
    end else if (CE) begin
      if (!FAULT) begin
        blink_cnt_q <= 26'h0000000;
        blink_q     <= 1'b0;
      end else if (blink_cnt_q == 26'(chgpins_pkg::BLINK_HALF_CYC - 1)) begin
        blink_cnt_q <= 26'h0000000;
        blink_q     <= !blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 26'h0000001;
      end
    end
  end

  // Status pin drive
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      STAT_OE <= 1'b0;
    end else if (CE) begin
      if (ctrl_q[chgpins_pkg::CTRL_STAT_OFF])
        STAT_OE <= 1'b0;
      else if (FAULT)
        STAT_OE <= !blink_q;
      else
        STAT_OE <= CHARGING && CHARGE_ON;
    end
  end

  // Alert lasts exactly the set length once started
  a_alert_len: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    $fell(ALERT_OE) |-> alert_hi_q == 16'(chgpins_pkg::ALERT_CYC))
    else $error("alert pulse length wrong");
  // Disabled status never drives
  a_stat_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && ctrl_q[chgpins_pkg::CTRL_STAT_OFF] |=> !STAT_OE) else $error("status driven");
  // Boost follows bit and pin
  a_boost_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE |=> BOOST_ON == $past(ctrl_q[chgpins_pkg::CTRL_BOOST] && boost_pin_q))
    else $error("boost gate");
  // Charge follows bit and low pin
  a_charge_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE |=> CHARGE_ON == $past(ctrl_q[chgpins_pkg::CTRL_CHARGE] && !ce_pin_q))
    else $error("charge gate");
  // Limit never above register
  a_limit_min: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE |=> EFF_LIMIT <= $past(lim_q)) else $error("limit too high");
  // Pin ignored when disabled
  a_limit_reg: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && !ctrl_q[chgpins_pkg::CTRL_PINLIM] |=> EFF_LIMIT == $past(lim_q))
    else $error("pin limit used");
  // D+ drives only with source or boost
  a_dplus_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
    DPLUS_OE |-> $past(SRC_PRESENT || BOOST_ON)) else $error("dplus drive");
  // D- drives only with source or boost
  a_dminus_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
    DMINUS_OE |-> $past(SRC_PRESENT || BOOST_ON)) else $error("dminus drive");
  // Detection ends within three cycles of the primary step
  a_det_bound: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    ds_q == chgpins_pkg::DS_PRIM |-> ##[1:3] ds_q == chgpins_pkg::DS_DONE)
    else $error("detection stuck");
  // Steady status without fault
  a_stat_steady: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && !FAULT && !ctrl_q[chgpins_pkg::CTRL_STAT_OFF] |=> STAT_OE == $past(CHARGING && CHARGE_ON))
    else $error("status level");

endmodule

// ---- chgpins_pkg.sv ----
// Purpose: Shared constants and carriers for the charger status/control pin block
// Assumes: 100 MHz system clock, register bus with one-cycle read latency
// Notes:   Offsets, control fields, the control, limit and mask reset values and timing counts live here
package chgpins_pkg;

  // Clock rate and documented times
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned BLINK_HZ      = 1;
  localparam int unsigned ALERT_US      = 256;
  // Half period of the fault blink, rounded down
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  // Alert pulse length, clock MHz rounded down, nothing added
  localparam int unsigned ALERT_CYC     = (ALERT_US * (CLK_HZ / 1_000_000) + 0) ;

  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DRIVE  = 8'h04;
  localparam logic [7:0] OFS_CURRENT_LIMIT_RESISTOR_PIN   = 8'h08;
  localparam logic [7:0] OFS_STATE  = 8'h0c;
  localparam logic [7:0] OFS_EVENT  = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;

  // Control register fields
  localparam int CTRL_STAT_OFF = 0;
  localparam int CTRL_BOOST    = 1;
  localparam int CTRL_CHARGE   = 2;
  localparam int CTRL_PINLIM   = 3;
  localparam int CTRL_DET      = 4;
  localparam logic [7:0] CTRL_RESET = 8'h0c;

  // Field widths and resets
  localparam int LVL_W   = 3;
  localparam int LIM_W   = 6;
  localparam logic [LIM_W-1:0] LIM_RESET = 6'h08;
  localparam logic [7:0] MASK_RESET = 8'hff;

  // Event bits
  localparam int EV_CHG   = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_DET   = 2;
  localparam int EV_W     = 3;

  // Port detection results
  typedef enum logic [2:0] {
    DET_NONE = 3'h0, DET_SDP = 3'h1, DET_CDP = 3'h2, DET_DCP = 3'h3, DET_HV = 3'h4
  } det_result_t;

  // Detection sequencer states, Gray along the path
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000, DS_DCD = 3'b001, DS_PRIM = 3'b011,
    DS_SEC = 3'b010, DS_HV = 3'b110, DS_DONE = 3'b111
  } det_state_t;

  // Data-line drive carrier
  typedef struct packed {
    logic             oe;
    logic [LVL_W-1:0] level;
  } line_drive_t;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

// ---- host_model.sv ----
// Purpose: Host side of the charger pins: enable pins and pulled-up open drains
// Assumes: Pull-ups hold the status and alert lines high when released
// Notes:   Counts alert pulses and keeps the width of the last one in cycles
`timescale 1ns/100ps
module host_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Requests from the bench
  input  wire logic        want_boost,
  input  wire logic        want_charge,
  // Open-drain enables from the device
  input  wire logic        stat_oe,
  input  wire logic        alert_oe,
  // Host pins, resolved lines and alert statistics
  output logic             boost_pin = 1'b0,
  output logic             charge_en_n = 1'b1,
  output logic             stat_line,
  output logic             alert_line,
  output logic [31:0]      alert_len,
  output logic [31:0]      alert_cnt
);
  logic [31:0] run_q; // Low time of the alert line so far

  // Pull-ups win whenever the device lets go of a line
  assign stat_line  = stat_oe ? 1'b0 : 1'b1;
  assign alert_line = alert_oe ? 1'b0 : 1'b1;

  // Host pins always sit at a defined level, moved just after the edge
  always @(posedge clk) begin
    boost_pin   <= want_boost;
    charge_en_n <= ~want_charge;
  end

  // Measure each low pulse of the alert line
  always @(posedge clk) begin
    if (rst) begin
      run_q     <= '0;
      alert_len <= '0;
      alert_cnt <= '0;
    end else if (!alert_line) begin
      run_q <= run_q + 32'h1;
    end else if (run_q != '0) begin
      alert_len <= run_q;
      alert_cnt <= alert_cnt + 32'h1;
      run_q     <= '0;
    end
  end
endmodule

// ---- tb_chgpins.sv ----
// Purpose: Self-checking bench for the charger status and control pin block
// Assumes: One 100 MHz clock, clock enable held high
// Notes: Pin-derived limits stay well above the lowest codes
`timescale 1ns/100ps
module tb_chgpins;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic        charging = 1'b0, fault = 1'b0, src = 1'b0;
  logic [5:0]  pin_limit = 6'h3f, eff_limit;
  logic        want_boost = 1'b0, want_charge = 1'b0, boost_pin, charge_en_n;
  logic        stat_oe, alert_oe, stat_line, alert_line, irq, boost_on, charge_on;
  logic        dp_oe, dm_oe, dp_in = 1'b0, dm_in = 1'b0;
  logic [2:0]  dp_lvl, dm_lvl, port_type;
  logic [31:0] alert_len, alert_cnt, rd_q, p0;
  int          failures = 0;
  int          n_checks = 0;

  // Free-running system clock
  always #5 clk = ~clk;

  chgpins chgpins_inst (.SYS_CLK(clk), .RST(rst), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .CHARGING(charging), .FAULT(fault),
    .SRC_PRESENT(src), .PIN_LIMIT(pin_limit), .BOOST_PIN(boost_pin),
    .CHARGE_EN_N(charge_en_n), .DPLUS_IN(dp_in), .DMINUS_IN(dm_in), .STAT_OE(stat_oe),
    .ALERT_OE(alert_oe), .DPLUS_OE(dp_oe), .DPLUS_LEVEL(dp_lvl), .DMINUS_OE(dm_oe),
    .DMINUS_LEVEL(dm_lvl), .BOOST_ON(boost_on), .CHARGE_ON(charge_on),
    .EFF_LIMIT(eff_limit), .PORT_TYPE(port_type), .IRQ(irq));

  host_model host_model_inst (.clk(clk), .rst(rst), .want_boost(want_boost),
    .want_charge(want_charge), .stat_oe(stat_oe), .alert_oe(alert_oe),
    .boost_pin(boost_pin), .charge_en_n(charge_en_n), .stat_line(stat_line),
    .alert_line(alert_line), .alert_len(alert_len), .alert_cnt(alert_cnt));

  // Compare and count, report at once
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rd_q = {24'h0, rdata};
  endtask

  // Let pin synchronisers and gated outputs land
  task automatic settle();
    repeat (10) @(posedge clk);
    #1;
  endtask

  // Reset values and an unmapped read
  task automatic t_reset();
    rd_reg(chgpins_pkg::OFS_CTRL);
    check("ctrl", rd_q, 32'(chgpins_pkg::CTRL_RESET));
    rd_reg(chgpins_pkg::OFS_CURRENT_LIMIT_RESISTOR_PIN);
    check("limit", rd_q, 32'(chgpins_pkg::LIM_RESET));
    rd_reg(chgpins_pkg::OFS_MASK);
    check("mask", rd_q, 32'(chgpins_pkg::MASK_RESET));
    rd_reg(8'h18);
    check("unmapped", rd_q, 32'h0);
    check("eff_limit", 32'(eff_limit), 32'(chgpins_pkg::LIM_RESET));
  endtask

  // Charge gating and the status line
  task automatic t_charge();
    @(posedge clk);
    want_charge <= 1'b1;
    charging    <= 1'b1;
    settle();
    check("charge_on", 32'(charge_on), 32'h1);
    check("stat low", 32'(stat_line), 32'h0);
    @(posedge clk);
    want_charge <= 1'b0;
    settle();
    check("charge_on pin", 32'(charge_on), 32'h0);
    check("stat released", 32'(stat_line), 32'h1);
    @(posedge clk);
    want_charge <= 1'b1;
    wr_reg(chgpins_pkg::OFS_CTRL, 8'h08);
    settle();
    check("charge_on cfg", 32'(charge_on), 32'h0);
    wr_reg(chgpins_pkg::OFS_CTRL, 8'h0d);
    settle();
    check("stat disabled", 32'(stat_line), 32'h1);
    wr_reg(chgpins_pkg::OFS_CTRL, 8'h0c);
  endtask

  // Boost needs both the config bit and the pin
  task automatic t_boost();
    for (int i = 0; i < 4; i++) begin
      wr_reg(chgpins_pkg::OFS_CTRL, 8'h0c | {6'h0, i[0], 1'b0});
      want_boost <= i[1];
      settle();
      check("boost_on", 32'(boost_on), 32'(i[0] & i[1]));
    end
    // Leave boost off so the driver test starts from idle
    wr_reg(chgpins_pkg::OFS_CTRL, 8'h0c);
    want_boost <= 1'b0;
  endtask

  // Data-line drivers only with a source or in boost
  task automatic t_drive();
    wr_reg(chgpins_pkg::OFS_DRIVE, 8'h15);
    settle();
    check("dp off", 32'(dp_oe), 32'h0);
    check("dm off", 32'(dm_oe), 32'h0);
    @(posedge clk);
    src <= 1'b1;
    settle();
    check("dp level", {28'h0, dp_oe, dp_lvl}, 32'hd);
    check("dm level", {28'h0, dm_oe, dm_lvl}, 32'ha);
    @(posedge clk);
    src <= 1'b0;
    wr_reg(chgpins_pkg::OFS_CTRL, 8'h0e);
    want_boost <= 1'b1;
    settle();
    check("dp boost", 32'(dp_oe), 32'h1);
    check("dm boost", 32'(dm_oe), 32'h1);
    @(posedge clk);
    want_boost <= 1'b0;
    wr_reg(chgpins_pkg::OFS_CTRL, 8'h0c);
  endtask

  // Effective limit is the smaller one, pin ignored when disabled
  task automatic t_limit();
    wr_reg(chgpins_pkg::OFS_CURRENT_LIMIT_RESISTOR_PIN, 8'h10);
    pin_limit <= 6'h0c;
    settle();
    check("lim pin", 32'(eff_limit), 32'h0c);
    @(posedge clk);
    pin_limit <= 6'h20;
    settle();
    check("lim reg", 32'(eff_limit), 32'h10);
    @(posedge clk);
    pin_limit <= 6'h0c;
    wr_reg(chgpins_pkg::OFS_CTRL, 8'h04);
    settle();
    check("lim nopin", 32'(eff_limit), 32'h10);
    wr_reg(chgpins_pkg::OFS_CTRL, 8'h0c);
  endtask

  // Port detection on a source attach with quiet data lines
  task automatic t_detect();
    wr_reg(chgpins_pkg::OFS_CTRL, 8'h1c);
    src <= 1'b1;
    for (int i = 0; i < 1000 && port_type === 3'h0; i++)
      @(posedge clk);
    #1;
    check("port", 32'(port_type), 32'(chgpins_pkg::DET_SDP));
    rd_reg(chgpins_pkg::OFS_EVENT);
    check("det event", rd_q & 32'h4, 32'h4);
    // Detach, then attach again with D- held high: charging host port
    @(posedge clk);
    src   <= 1'b0;
    dm_in <= 1'b1;
    settle();
    @(posedge clk);
    src <= 1'b1;
    for (int i = 0; i < 1000 && port_type !== chgpins_pkg::DET_CDP; i++)
      @(posedge clk);
    #1;
    check("port cdp", 32'(port_type), 32'(chgpins_pkg::DET_CDP));
    @(posedge clk);
    dm_in <= 1'b0;
    wr_reg(chgpins_pkg::OFS_CTRL, 8'h0c);
  endtask

  // Alert pulse width, no retrigger, first low phase of fault blink, interrupt masking
  task automatic t_alert();
    for (int i = 0; i < 30000 && !alert_line; i++)
      @(posedge clk);
    rd_reg(chgpins_pkg::OFS_EVENT);
    p0 = alert_cnt + 32'h1;
    @(posedge clk);
    charging <= ~charging;
    repeat (100) @(posedge clk);
    fault <= 1'b1;
    for (int i = 0; i < 30000 && alert_cnt != p0; i++)
      @(posedge clk);
    check("alert len", alert_len, chgpins_pkg::ALERT_CYC);
    repeat (300) @(posedge clk);
    #1;
    check("alert count", alert_cnt, p0);
    check("fault blink", 32'(stat_line), 32'h0);
    check("irq set", 32'(irq), 32'h1);
    wr_reg(chgpins_pkg::OFS_MASK, 8'h00);
    settle();
    check("irq masked", 32'(irq), 32'h0);
    wr_reg(chgpins_pkg::OFS_MASK, 8'hff);
    rd_reg(chgpins_pkg::OFS_EVENT);
    check("events", rd_q & 32'h3, 32'h3);
    settle();
    check("irq cleared", 32'(irq), 32'h0);
    @(posedge clk);
    fault <= 1'b0;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_charge();
    t_boost();
    t_drive();
    t_limit();
    t_detect();
    t_alert();
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    #900000;
    failures++;
    tally_and_finish();
  end
endmodule
